// ### sapf_pkg.sv
// Function
// - power-fail compare uses threshold against upper eight result bits only
// - every threshold register write inserts one bus wait cycle
// - first step trials bit 9 at half reference, keeps it if at or above
// - later bits trial one, tap from decided bits, keep if input >= tap
// - after ten compares, latch result and signal done per mode
// - conversions repeat back to back while run bit stays set
// - any converter register write aborts conversion, restarts if run set
// - writing run zero stops conversion at once, result keeps last value
// - result word is left justified, approximation times 64
// - compare disabled: store result and interrupt on every conversion
// - compare enabled, polarity zero: interrupt when upper byte >= threshold
// - compare enabled, polarity one: interrupt when upper byte < threshold
// - each new result overwrites the result register unconditionally
// - channel change to next done is selected conversion time plus one idle cycle
// - channel from channel bits 1:0, time from mode 5:3, run 7, ref 0
// - compare enable is power-fail mode bit 7, polarity bit 6
// - lower six bits of the result word always read zero
// - result read colliding with end-of-conversion returns old value first
// - mode or channel write at conversion end skips result and interrupt
package sapf_pkg;

  // register addresses on the cpu data bus
  localparam logic [15:0] ADDR_RESULT_LO = 16'hFF08;
  localparam logic [15:0] ADDR_RESULT_HI = 16'hFF09;
  localparam logic [15:0] ADDR_MODE = 16'hFF28;
  localparam logic [15:0] ADDR_CHANNEL = 16'hFF29;
  localparam logic [15:0] ADDR_PF_MODE = 16'hFF2A;
  localparam logic [15:0] ADDR_THRESHOLD = 16'hFF2B;

  // field positions
  localparam int RUN_BIT = 7;
  localparam int REF_BIT = 0;
  localparam int TIME_LSB = 3;
  localparam int TIME_MSB = 5;
  localparam int PF_EN_BIT = 7;
  localparam int PF_POL_BIT = 6;
  localparam int MSB_IDX = 9;
  localparam int RES_BITS = 10;
  localparam int ZERO_BITS = 6;

  localparam logic [7:0] MODE_WMASK = 8'hB9;
  localparam logic [7:0] CHAN_WMASK = 8'h03;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [3:0] FIRST_IDX = 4'h9;

  typedef enum logic [2:0] {
    SAPF_IDLE = 3'b001,
    SAPF_SAMPLE = 3'b010,
    SAPF_CONV = 3'b100
  } sapf_state_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sapf_bus_req_t;

  typedef struct packed {
    sapf_state_t st;
    logic [11:0] cnt;
    logic [3:0] idx;
    logic [9:0] tap;
    logic [9:0] result;
    logic [7:0] mode;
    logic [1:0] chan;
    logic pf_en;
    logic pf_pol;
    logic [7:0] thr;
    logic [7:0] rdata;
    logic wait_cyc;
    logic irq;
    logic sampling;
    logic cmp_meta;
    logic cmp_sync;
  } sapf_regs_t;

endpackage : sapf_pkg

// ### sapf_ctrl.sv
`timescale 1ns/10ps
module sapf_ctrl #(
  parameter int SAMPLE_BASE = 8,
  parameter int STEP_BASE = 4
) (
  // clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // cpu data bus
  input wire sapf_pkg::sapf_bus_req_t bus_i,
  output logic [7:0] rdata_o,
  output logic wait_o,
  // analog front end
  input wire logic cmp_i,
  output logic [9:0] tap_o,
  output logic sample_o,
  output logic [1:0] channel_o,
  output logic ref_enable_o,
  // conversion outputs
  output logic irq_o,
  output logic [9:0] result_o
);
  import sapf_pkg::*;

  sapf_regs_t q;
  sapf_regs_t d;
  logic wr_conv;
  logic wr_mode_chan;
  logic [9:0] bit_mask;
  logic [9:0] decided;
  logic [7:0] upper;
  logic hit;
  logic [11:0] speed;

  always_comb
  begin
    wr_conv = bus_i.wr && (bus_i.addr == ADDR_MODE ||
      bus_i.addr == ADDR_CHANNEL || bus_i.addr == ADDR_PF_MODE ||
      bus_i.addr == ADDR_THRESHOLD);
    wr_mode_chan = bus_i.wr && (bus_i.addr == ADDR_MODE ||
      bus_i.addr == ADDR_CHANNEL);
    bit_mask = 10'(10'h001 << q.idx);
    // comparator high means input at or above the trial tap
    decided = q.cmp_sync ? q.tap : (q.tap & ~bit_mask);
    upper = decided[MSB_IDX -: 8];
    if (!q.pf_en)
      hit = 1'b1;
    else if (q.pf_pol)
      hit = upper < q.thr;
    else
      hit = upper >= q.thr;
    speed = 12'(q.mode[TIME_MSB:TIME_LSB]) + 12'h001;
  end

  always_comb
  begin
    d = q;
    d.wait_cyc = 1'b0;
    d.irq = 1'b0;
    d.cmp_meta = cmp_i;
    d.cmp_sync = q.cmp_meta;

    if (bus_i.rd)
    begin
      case (bus_i.addr)
        // old result goes out even if a conversion ends now
        ADDR_RESULT_LO: d.rdata = {q.result[1:0], 6'h00};
        ADDR_RESULT_HI: d.rdata = q.result[MSB_IDX -: 8];
        ADDR_MODE: d.rdata = q.mode;
        ADDR_CHANNEL: d.rdata = {6'h00, q.chan};
        ADDR_PF_MODE: d.rdata = {q.pf_en, q.pf_pol, 6'h00};
        ADDR_THRESHOLD: d.rdata = q.thr;
        default: d.rdata = RESET_BYTE;
      endcase
      if (bus_i.addr == ADDR_RESULT_LO || bus_i.addr == ADDR_RESULT_HI)
        d.wait_cyc = 1'b1;
    end

    if (bus_i.wr)
    begin
      case (bus_i.addr)
        ADDR_MODE: d.mode = bus_i.wdata & MODE_WMASK;
        ADDR_CHANNEL: d.chan = bus_i.wdata[1:0];
        ADDR_PF_MODE:
        begin
          d.pf_en = bus_i.wdata[PF_EN_BIT];
          d.pf_pol = bus_i.wdata[PF_POL_BIT];
        end
        ADDR_THRESHOLD: d.thr = bus_i.wdata;
        default: d.thr = q.thr;
      endcase
      if (wr_conv)
        d.wait_cyc = 1'b1;
    end

    case (q.st)
      SAPF_IDLE:
      begin
        d.sampling = 1'b0;
        if (q.mode[RUN_BIT])
        begin
          d.st = SAPF_SAMPLE;
          d.cnt = 12'(SAMPLE_BASE) * speed;
          d.sampling = 1'b1;
        end
      end
      SAPF_SAMPLE:
      begin
        d.cnt = q.cnt - 12'h001;
        if (q.cnt == 12'h001)
        begin
          d.st = SAPF_CONV;
          d.sampling = 1'b0;
          d.idx = FIRST_IDX;
          d.tap = 10'h200;
          d.cnt = 12'(STEP_BASE) * speed;
        end
      end
      SAPF_CONV:
      begin
        d.cnt = q.cnt - 12'h001;
        if (q.cnt == 12'h001)
        begin
          if (q.idx == 4'h0)
          begin
            d.result = decided;
            d.irq = hit;
            d.st = SAPF_SAMPLE;
            d.cnt = 12'(SAMPLE_BASE) * speed;
            d.sampling = 1'b1;
          end
          else
          begin
            d.idx = q.idx - 4'h1;
            d.tap = decided | (bit_mask >> 1);
            d.cnt = 12'(STEP_BASE) * speed;
          end
        end
      end
      default:
      begin
        d.st = SAPF_IDLE;
        d.sampling = 1'b0;
      end
    endcase

    // a register write beats a finishing conversion; in idle it also
    // holds off the start for one cycle, so a stop written then sticks
    if (wr_conv)
    begin
      d.st = SAPF_IDLE;
      d.sampling = 1'b0;
      d.irq = 1'b0;
      d.result = q.result;
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      q.st <= SAPF_IDLE;
      q.cnt <= 12'h000;
      q.idx <= 4'h0;
      q.tap <= 10'h000;
      q.result <= 10'h000;
      q.mode <= RESET_BYTE;
      q.chan <= 2'h0;
      q.pf_en <= 1'b0;
      q.pf_pol <= 1'b0;
      q.thr <= RESET_BYTE;
      q.rdata <= RESET_BYTE;
      q.wait_cyc <= 1'b0;
      q.irq <= 1'b0;
      q.sampling <= 1'b0;
      q.cmp_meta <= 1'b0;
      q.cmp_sync <= 1'b0;
    end
    else if (ce_i)
    begin
      q <= d;
    end
  end

  assign rdata_o = q.rdata;
  assign wait_o = q.wait_cyc;
  assign tap_o = q.tap;
  assign sample_o = q.sampling;
  assign channel_o = q.chan;
  assign ref_enable_o = q.mode[REF_BIT];
  assign irq_o = q.irq;
  assign result_o = q.result;

  irq_high_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    (irq_o && q.pf_en && !q.pf_pol) |-> (result_o[9:2] >= q.thr))
    else $error("interrupt raised below threshold");

  irq_low_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    (irq_o && q.pf_en && q.pf_pol) |-> (result_o[9:2] < q.thr))
    else $error("interrupt raised at or above threshold");

  thr_wait_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    (ce_i && bus_i.wr && bus_i.addr == ADDR_THRESHOLD) |=> wait_o)
    else $error("threshold write without wait cycle");

  low_zero_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    (ce_i && bus_i.rd && bus_i.addr == ADDR_RESULT_LO) |=>
      (rdata_o[5:0] == 6'h00 && rdata_o[7:6] == $past(result_o[1:0])))
    else $error("low result byte wrong");

  write_abort_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    (ce_i && wr_conv && q.st != SAPF_IDLE) |=>
      (q.st == SAPF_IDLE && !irq_o && !sample_o))
    else $error("write did not abort conversion");

  run_stop_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    (ce_i && bus_i.wr && bus_i.addr == ADDR_MODE && !bus_i.wdata[RUN_BIT])
      |=> (q.st == SAPF_IDLE) ##1 (q.st == SAPF_IDLE))
    else $error("conversion kept running after stop");

  first_tap_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    $rose(q.st == SAPF_CONV) |-> (tap_o == 10'h200 && q.idx == FIRST_IDX))
    else $error("first trial is not half reference");

  back_to_back_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    irq_o |-> (q.st == SAPF_SAMPLE && sample_o))
    else $error("no new sample after conversion end");

  result_load_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    (ce_i && q.st == SAPF_CONV && q.idx == 4'h0 && q.cnt == 12'h001
      && !wr_conv) |=> (result_o == $past(decided)))
    else $error("result not overwritten at conversion end");

  end_skip_a: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    (ce_i && wr_mode_chan && q.st == SAPF_CONV && q.idx == 4'h0
      && q.cnt == 12'h001) |=> (!irq_o && $stable(result_o)))
    else $error("end write did not skip result");

endmodule : sapf_ctrl

// ### sapf_front.sv
`timescale 1ns/10ps
module sapf_front (
  // analog inputs and tap from the converter
  input wire logic [3:0][9:0] ain_i,
  input wire logic [1:0] chan_i,
  input wire logic [9:0] tap_i,
  input wire logic sample_i,
  // comparator decision
  output logic cmp_o
);
  logic [9:0] held = 10'h000;

  // hold capacitor tracks the channel while sampling, keeps it after
  always @(sample_i or chan_i or ain_i)
    if (sample_i)
      held = ain_i[chan_i];
  assign cmp_o = (held >= tap_i);
endmodule : sapf_front

// ### sapf_ctrl_bench.sv
`timescale 1ns/10ps
module sapf_ctrl_bench;
  import sapf_pkg::*;
  localparam int SB = 4;
  localparam int TB = 3;
  logic clk_sys_i, reset_i, wait_s, cmp, smp, refen, irq, got, pol, ce;
  sapf_bus_req_t bus;
  logic [7:0] rdata, rb, thr;
  logic [9:0] tap, res, rv;
  logic [1:0] chan, cn;
  logic [2:0] tc;
  logic [3:0][9:0] ain;
  int n_fail, n_checks, cyc, n_irq, t_irq, seed, i, p, k, t0, cv;

  sapf_ctrl #(.SAMPLE_BASE(SB), .STEP_BASE(TB)) uut (.clk_sys_i(clk_sys_i),
    .reset_i(reset_i), .ce_i(ce), .bus_i(bus), .rdata_o(rdata),
    .wait_o(wait_s), .cmp_i(cmp), .tap_o(tap), .sample_o(smp),
    .channel_o(chan), .ref_enable_o(refen), .irq_o(irq), .result_o(res));
  sapf_front front (.ain_i(ain), .chan_i(chan), .tap_i(tap),
    .sample_i(smp), .cmp_o(cmp));

  initial
  begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  always @(posedge clk_sys_i)
  begin
    cyc <= cyc + 1;
    if (irq === 1'b1)
    begin
      n_irq <= n_irq + 1;
      t_irq <= cyc;
    end
    if (cyc == 20000)
    begin
      n_fail = n_fail + 1;
      print_verdict();
    end
  end

  task automatic chk_byte(string nm, logic [7:0] e, logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_byte

  task automatic chk_res(string nm, logic [9:0] e, logic [9:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_res

  task automatic chk_bit(string nm, logic e, logic g);
    n_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit

  task automatic wr(logic [15:0] a, logic [7:0] d);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys_i);
    bus.wr <= 1'b0;
    #1 chk_bit("wait", 1'b1, wait_s);
    @(posedge clk_sys_i);
  endtask : wr

  task automatic rd(logic [15:0] a, output logic [7:0] d);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_sys_i);
    bus.rd <= 1'b0;
    #1 d = rdata;
    @(posedge clk_sys_i);
  endtask : rd

  // returns at the edge after the pulse so result_o has settled
  task automatic wait_irq(int lim, output logic g);
    int k0;
    k0 = n_irq;
    for (int j = 0; j < lim && n_irq == k0; j++)
      @(posedge clk_sys_i);
    g = (n_irq != k0);
  endtask : wait_irq

  initial
  begin
    {cyc, n_irq, t_irq, n_fail, n_checks} = '0;
    seed = 54792;
    bus = '0;
    ain = '0;
    reset_i = 1'b1;
    ce = 1'b1;
    repeat (16) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    @(posedge clk_sys_i);
    rd(ADDR_THRESHOLD, rb);
    chk_byte("thr reset", 8'h00, rb);
    wr(ADDR_THRESHOLD, 8'hA5);
    rd(ADDR_THRESHOLD, rb);
    chk_byte("thr", 8'hA5, rb);
    rd(16'hFF00, rb);
    chk_byte("unmapped", 8'h00, rb);
    $display("register test done");
    wr(ADDR_MODE, 8'h01); // reference before run
    repeat (20) @(posedge clk_sys_i);
    for (i = 0; i < 6; i++)
    begin
      tc = 3'($random(seed));
      cn = 2'($random(seed));
      cv = (SB + 10 * TB) * (tc + 1);
      for (p = 0; p < 4; p++)
        ain[p] <= 10'($random(seed));
      wr(ADDR_MODE, {2'b10, tc, 3'b001});
      t0 = cyc;
      wr(ADDR_CHANNEL, {6'h00, cn});
      wait_irq(3 * cv, got);
      chk_bit("irq", 1'b1, got);
      chk_bit("latency", 1'b1, t_irq - t0 >= cv && t_irq - t0 <= cv + 4);
      chk_res("result", ain[cn], res);
      k = t_irq;
      ain[cn] <= ~ain[cn];
      wait_irq(2 * cv, got);
      chk_bit("period", 1'b1, t_irq - k == cv);
      chk_res("overwrite", ain[cn], res);
      rd(ADDR_RESULT_HI, rb);
      chk_byte("result hi", ain[cn][9:2], rb);
      rd(ADDR_RESULT_LO, rb);
      chk_byte("result lo", {ain[cn][1:0], 6'h00}, rb);
      // land a channel write exactly on the next conversion end
      k = n_irq;
      while (cyc != t_irq + cv - 2)
        @(posedge clk_sys_i);
      wr(ADDR_CHANNEL, {6'h00, cn});
      @(posedge clk_sys_i);
      chk_bit("end write", 1'b0, n_irq != k);
    end
    $display("conversion test done");
    for (i = 0; i < 8; i++)
    begin
      pol = i[0];
      rv = 10'($random(seed));
      ain[cn] <= rv;
      thr = i[1] ? rv[9:2] : 8'($random(seed));
      wr(ADDR_THRESHOLD, thr);
      wr(ADDR_PF_MODE, {1'b1, pol, 6'h00});
      wait_irq(2 * cv + 8, got);
      chk_bit("pf irq", (ain[cn][9:2] >= thr) ^ pol, got);
      rd(ADDR_RESULT_HI, rb);
      chk_byte("pf result", ain[cn][9:2], rb);
    end
    $display("compare test done");
    wr(ADDR_PF_MODE, 8'h00);
    ce <= 1'b0;
    wait_irq(2 * cv + 8, got);
    chk_bit("frozen", 1'b0, got);
    ce <= 1'b1;
    wait_irq(2 * cv + 8, got);
    chk_bit("thawed", 1'b1, got);
    $display("enable test done");
    wr(ADDR_MODE, {2'b00, tc, 3'b001});
    wait_irq(2 * cv + 8, got);
    chk_bit("stopped", 1'b0, got);
    wr(ADDR_MODE, 8'h00);
    $display("stop test done");
    print_verdict();
  end
endmodule : sapf_ctrl_bench
